// file: afpc_defines.svh
`ifndef AFPC_DEFINES_SVH
`define AFPC_DEFINES_SVH

`define AFPC_DATA_W        12
`define AFPC_FULL_SCALE    12'hfff
`define AFPC_MSB_POS       11
`define AFPC_CLK_MHZ       125
`define AFPC_NAP_WAKE_NS   1000
`define AFPC_NAP_WAKE_CYC  ((`AFPC_NAP_WAKE_NS * `AFPC_CLK_MHZ) / 1000)
`define AFPC_SLEEP_WAKE_US 1000
`define AFPC_SLEEP_WAKE_CYC (`AFPC_SLEEP_WAKE_US * `AFPC_CLK_MHZ)
`define AFPC_TRI_LOW       2'h0
`define AFPC_TRI_FLOAT     2'h1
`define AFPC_TRI_HIGH      2'h2

`endif

// file: afpc_pkg.sv
`default_nettype none
package afpc_pkg;
  typedef enum logic [1:0] {
    AFPC_CODE_OFFSET = 2'h0,
    AFPC_CODE_TWOS   = 2'h1,
    AFPC_CODE_GRAY   = 2'h2
  } afpc_coding_t;

  typedef enum logic [1:0] {
    AFPC_STYLE_CMOS    = 2'h0,
    AFPC_STYLE_DIFF3MA = 2'h1,
    AFPC_STYLE_DIFF2MA = 2'h2
  } afpc_style_t;

  typedef enum logic [3:0] {
    AFPC_PWR_RUN   = 4'h1,
    AFPC_PWR_NAP   = 4'h2,
    AFPC_PWR_SLEEP = 4'h4,
    AFPC_PWR_WAKE  = 4'h8
  } afpc_pwr_t;
endpackage
`default_nettype wire

// file: afpc_skid_buffer.sv
`timescale 1ns/1ns
`default_nettype none
`include "afpc_defines.svh"

module afpc_skid_buffer (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    clkEn,
  input  wire logic                    inValid,
  output logic                         inReady,
  input  wire logic [`AFPC_DATA_W:0]   inData,
  output logic                         outValid,
  input  wire logic                    outReady,
  output logic      [`AFPC_DATA_W:0]   outData
);
  typedef struct packed {
    logic [1:0][`AFPC_DATA_W:0] mem;
    logic                       wrPtr;
    logic                       rdPtr;
    logic [1:0]                 count;
  } afpc_skid_state_t;

  afpc_skid_state_t st_r;
  afpc_skid_state_t st_nxt;
  logic             doWr;
  logic             doRd;

  assign inReady  = (st_r.count != 2'h2);
  assign outValid = (st_r.count != 2'h0);
  assign outData  = st_r.mem[st_r.rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    st_nxt = st_r;
    if (doWr) begin
      st_nxt.mem[st_r.wrPtr] = inData;
      st_nxt.wrPtr = ~st_r.wrPtr;
    end
    if (doRd) begin
      st_nxt.rdPtr = ~st_r.rdPtr;
    end
    if (doWr && !doRd) begin
      st_nxt.count = st_r.count + 2'h1;
    end else if (doRd && !doWr) begin
      st_nxt.count = st_r.count - 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// file: afpc_output_ctrl.sv
// Summary of operation
// - in ddr mode drive only even data pins, odd pins stay disabled
// - ddr: clock low shows msb and odd bits, high shows lsb and even bits
// - style strap low cmos, float differential 3ma, high differential 2ma
// - serial-programmed output style overrides the style strap
// - over-range flag set when the output code reaches offset binary all ones
// - over-range code saturates at full scale, never wraps
// - over-range flag updated once per sample
// - nap wakes in about 1 us, sleep needs about 1 ms after wake
// - nap or sleep disables data, forwarded clock and over-range outputs
// - after power-on power strap picks run, sleep or nap
// - serial power state overrides strap, only for indexed converter
// - coding strap low offset binary, float two's complement, high gray
// - serial-programmed coding overrides the coding strap
// - offset binary maps most negative to zeros, most positive to ones
// - two's complement inverts only the msb of offset binary
// - gray keeps msb, other bits xor with next higher binary bit
// - over-range flag forced high while calibration reset is low
// - forwarded clock held low during calibration reset, resumes after
`timescale 1ns/1ns
`default_nettype none
`include "afpc_defines.svh"

module afpc_output_ctrl (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      clkEn,
  input  wire logic                      sampleClk,
  input  wire logic                      sampleValid,
  output logic                           sampleReady,
  input  wire logic [`AFPC_DATA_W-1:0]   sampleRaw,
  input  wire logic                      sampleOverRange,
  input  wire logic                      calibrationResetN,
  input  wire logic                      calibrationDone,
  input  wire logic                      ddrMode,
  input  wire logic [1:0]                outputStyleStrap,
  input  wire logic [1:0]                powerStateStrap,
  input  wire logic [1:0]                outputCodingStrap,
  input  wire logic                      styleOverride,
  input  wire logic [1:0]                styleProgrammed,
  input  wire logic                      codingOverride,
  input  wire logic [1:0]                codingProgrammed,
  input  wire logic                      powerOverride,
  input  wire logic [1:0]                powerProgrammed,
  input  wire logic                      converterIndexed,
  output logic      [`AFPC_DATA_W-1:0]   sampleData,
  output logic      [`AFPC_DATA_W-1:0]   sampleDataOe,
  output logic                           forwardedSampleClock,
  output logic                           forwardedSampleClockOe,
  output logic                           overRange,
  output logic                           overRangeOe,
  output logic      [1:0]                outputStyle,
  output logic      [1:0]                outputCoding,
  output logic      [3:0]                powerState,
  output logic                           powerReady
);
  localparam int SLEEP_CYC = `AFPC_SLEEP_WAKE_CYC;
  localparam int NAP_CYC   = `AFPC_NAP_WAKE_CYC;

  typedef struct packed {
    logic [2:0]               clkSync;
    logic [2:0]               rstSync;
    logic                     clkLvl;
    logic                     calLvl;
    logic                     calDone;
    logic                     strapTaken;
    logic [1:0]               pwrStrapLat;
    logic [2:0][5:0]          strapSync;
    logic [5:0]               strapLvl;
    logic [1:0]               strapAge;
    afpc_pkg::afpc_pwr_t      pwr;
    afpc_pkg::afpc_pwr_t      pwrTarget;
    logic [16:0]              wakeCnt;
    logic [`AFPC_DATA_W-1:0]  word;
    logic                     orFlag;
    logic                     fwdClk;
    logic [`AFPC_DATA_W-1:0]  pins;
  } afpc_state_t;

  afpc_state_t st_r;
  afpc_state_t st_nxt;

  logic                        bufInReady;
  logic                        bufOutValid;
  logic                        bufOutReady;
  logic [`AFPC_DATA_W:0]       bufOutData;
  logic [`AFPC_DATA_W:0]       bufInData;
  logic [`AFPC_DATA_W-1:0]     coded;
  logic                        codedOr;
  logic [`AFPC_DATA_W-1:0]     satBin;
  logic [`AFPC_DATA_W-1:0]     ddrLow;
  logic [`AFPC_DATA_W-1:0]     ddrHigh;
  logic                        clkRise;
  logic                        clkFall;
  logic                        clkStable;
  logic                        calStable;
  logic                        active;
  afpc_pkg::afpc_pwr_t         pwrReq;
  logic [1:0]                  pwrSel;
  logic [5:0]                  strapRaw;
  logic [5:0]                  strapStable;

  // saturate, flag and code one sample together
  assign codedOr = sampleOverRange || (sampleRaw == `AFPC_FULL_SCALE);
  assign satBin  = sampleOverRange ? `AFPC_FULL_SCALE : sampleRaw;

  always_comb begin
    unique case (outputCoding)
      afpc_pkg::AFPC_CODE_TWOS: coded = satBin ^ 12'h800;
      afpc_pkg::AFPC_CODE_GRAY: coded = satBin ^ (satBin >> 1);
      default:                  coded = satBin;
    endcase
  end

  assign bufInData = {codedOr, coded};

  afpc_skid_buffer u_buf (
    .mclk     (mclk),
    .rst      (rst),
    .clkEn    (clkEn),
    .inValid  (sampleValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );
  assign sampleReady = bufInReady;

  // strap pins are asynchronous: each bit counts once flops two and three agree
  assign strapRaw = {outputCodingStrap, powerStateStrap, outputStyleStrap};
  genvar b;
  generate
    for (b = 0; b < 6; b = b + 1) begin : g_strap
      assign strapStable[b] = (st_r.strapSync[1][b] == st_r.strapSync[2][b]);
    end
  endgenerate

  // style and coding: programmed value wins over strap
  assign outputStyle  = styleOverride ? styleProgrammed : st_r.strapLvl[1:0];
  assign outputCoding = codingOverride ? codingProgrammed : st_r.strapLvl[5:4];

  // the ddr pin images, bit pairs interleaved onto even pins
  genvar g;
  generate
    for (g = 0; g < `AFPC_DATA_W; g = g + 2) begin : g_ddr
      assign ddrLow[g]    = st_r.word[g+1];
      assign ddrHigh[g]   = st_r.word[g];
      assign ddrLow[g+1]  = 1'b0;
      assign ddrHigh[g+1] = 1'b0;
    end
  endgenerate

  assign clkStable = (st_r.clkSync[1] == st_r.clkSync[2]);
  assign calStable = (st_r.rstSync[1] == st_r.rstSync[2]);
  assign clkRise   = clkStable && st_r.clkSync[2] && !st_r.clkLvl;
  assign clkFall   = clkStable && !st_r.clkSync[2] && st_r.clkLvl;
  assign active    = (st_r.pwr == afpc_pkg::AFPC_PWR_RUN);
  assign bufOutReady = clkRise && active;

  assign pwrSel = (powerOverride && converterIndexed) ? powerProgrammed
                                                      : st_r.pwrStrapLat;
  always_comb begin
    unique case (pwrSel)
      `AFPC_TRI_FLOAT: pwrReq = afpc_pkg::AFPC_PWR_SLEEP;
      `AFPC_TRI_HIGH:  pwrReq = afpc_pkg::AFPC_PWR_NAP;
      default:         pwrReq = afpc_pkg::AFPC_PWR_RUN;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.clkSync = {st_r.clkSync[1:0], sampleClk};
    st_nxt.rstSync = {st_r.rstSync[1:0], calibrationResetN};
    if (clkStable) begin
      st_nxt.clkLvl = st_r.clkSync[2];
    end
    if (calStable) begin
      st_nxt.calLvl = st_r.rstSync[2];
    end
    st_nxt.strapSync = {st_r.strapSync[1:0], strapRaw};
    st_nxt.strapLvl  = (st_r.strapLvl & ~strapStable) | (st_r.strapSync[2] & strapStable);
    // power strap taken once, after the synchroniser has filled
    if (!st_r.strapTaken) begin
      if (st_r.strapAge == 2'h3) begin
        st_nxt.strapTaken  = 1'b1;
        st_nxt.pwrStrapLat = st_nxt.strapLvl[3:2];
      end else begin
        st_nxt.strapAge = st_r.strapAge + 2'h1;
      end
    end
    if (!st_r.calLvl) begin
      st_nxt.calDone = 1'b0;
    end else if (calibrationDone) begin
      st_nxt.calDone = 1'b1;
    end
    unique case (st_r.pwr)
      afpc_pkg::AFPC_PWR_RUN: begin
        if (st_r.strapTaken && pwrReq != afpc_pkg::AFPC_PWR_RUN) begin
          st_nxt.pwr = pwrReq;
        end
      end
      afpc_pkg::AFPC_PWR_NAP, afpc_pkg::AFPC_PWR_SLEEP: begin
        if (pwrReq != st_r.pwr) begin
          st_nxt.pwr       = afpc_pkg::AFPC_PWR_WAKE;
          st_nxt.pwrTarget = pwrReq;
          st_nxt.wakeCnt   = (st_r.pwr == afpc_pkg::AFPC_PWR_SLEEP)
                             ? 17'(SLEEP_CYC - 1) : 17'(NAP_CYC - 1);
        end
      end
      afpc_pkg::AFPC_PWR_WAKE: begin
        if (st_r.wakeCnt == 17'h0) begin
          st_nxt.pwr = st_r.pwrTarget;
        end else begin
          st_nxt.wakeCnt = st_r.wakeCnt - 17'h1;
        end
      end
    endcase
    if (!st_r.calLvl) begin
      st_nxt.fwdClk = 1'b0;
    end else if (clkRise) begin
      st_nxt.fwdClk = 1'b1;
    end else if (clkFall) begin
      st_nxt.fwdClk = 1'b0;
    end
    if (bufOutReady && bufOutValid) begin
      st_nxt.word   = bufOutData[`AFPC_DATA_W-1:0];
      st_nxt.orFlag = bufOutData[`AFPC_DATA_W];
    end
    if (ddrMode) begin
      st_nxt.pins = st_nxt.fwdClk ? ddrHigh : ddrLow;
    end else begin
      st_nxt.pins = st_r.word;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '{clkSync: 3'h0, rstSync: 3'h0, clkLvl: 1'b0, calLvl: 1'b0,
                calDone: 1'b0, strapTaken: 1'b0, pwrStrapLat: 2'h0,
                strapSync: 18'h0, strapLvl: 6'h0, strapAge: 2'h0,
                pwr: afpc_pkg::AFPC_PWR_RUN, pwrTarget: afpc_pkg::AFPC_PWR_RUN,
                wakeCnt: 17'h0, word: 12'h000, orFlag: 1'b0, fwdClk: 1'b0,
                pins: 12'h000};
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign sampleData   = st_r.pins;
  assign sampleDataOe = !active ? 12'h000 : (ddrMode ? 12'h555 : 12'hfff);
  assign forwardedSampleClock   = st_r.fwdClk;
  assign forwardedSampleClockOe = active;
  assign overRange   = !st_r.calDone || st_r.orFlag;
  assign overRangeOe = active;
  assign powerState  = st_r.pwr;
  assign powerReady  = active;
endmodule
`default_nettype wire

// file: afpc_output_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module afpc_output_ctrl_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        calibrationResetN,
  input wire logic        calibrationDone,
  input wire logic        ddrMode,
  input wire logic [1:0]  outputStyleStrap,
  input wire logic [1:0]  outputCodingStrap,
  input wire logic        styleOverride,
  input wire logic [1:0]  styleProgrammed,
  input wire logic        codingOverride,
  input wire logic [1:0]  codingProgrammed,
  input wire logic [11:0] sampleData,
  input wire logic [11:0] sampleDataOe,
  input wire logic        forwardedSampleClock,
  input wire logic        forwardedSampleClockOe,
  input wire logic        overRange,
  input wire logic        overRangeOe,
  input wire logic [1:0]  outputStyle,
  input wire logic [1:0]  outputCoding,
  input wire logic [3:0]  powerState,
  input wire logic        powerReady
);
  logic calOk_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) calOk_r <= 1'b0;
    else calOk_r <= calibrationResetN && (calOk_r || calibrationDone);
  end
  sequence calHeldLow;
    !calibrationResetN [*6];
  endsequence
  sequence orRoseOffsetSdr;
    calOk_r && powerReady && !ddrMode && outputCoding == 2'h0 && $rose(overRange);
  endsequence
  sequence styleSettled;
    $stable(outputStyleStrap) [*5];
  endsequence
  sequence codingSettled;
    $stable(outputCodingStrap) [*5];
  endsequence
  a_ddr_even_pins: assert property (powerReady && ddrMode |-> sampleDataOe == 12'h555)
    else $error("ddr pin enables wrong");
  a_sdr_all_pins: assert property (powerReady && !ddrMode |-> sampleDataOe == 12'hfff)
    else $error("sdr pin enables wrong");
  a_low_power_hiz: assert property (powerState != afpc_pkg::AFPC_PWR_RUN |->
    sampleDataOe == 12'h000 && !forwardedSampleClockOe && !overRangeOe)
    else $error("outputs driven outside run");
  a_style_pick: assert property (styleSettled |-> outputStyle ==
    (styleOverride ? styleProgrammed : outputStyleStrap)) else $error("style selection wrong");
  a_coding_pick: assert property (codingSettled |-> outputCoding ==
    (codingOverride ? codingProgrammed : outputCodingStrap)) else $error("coding selection wrong");
  a_cal_clock_low: assert property (calHeldLow |-> !forwardedSampleClock)
    else $error("forwarded clock runs in calibration reset");
  a_cal_flag_high: assert property (calHeldLow |-> overRange)
    else $error("over-range low in calibration reset");
  a_flag_saturates: assert property (orRoseOffsetSdr |=> sampleData == 12'hfff)
    else $error("over-range word not full scale");
endmodule
bind afpc_output_ctrl afpc_output_ctrl_assertions u_chk (.*);
`default_nettype wire

// file: afpc_receiver_model.sv
`timescale 1ns/1ns
`default_nettype none
module afpc_receiver_model (
  input  wire logic        mclk,
  input  wire logic        forwardedSampleClock,
  input  wire logic [11:0] sampleData,
  input  wire logic [11:0] sampleDataOe,
  input  wire logic        ddrMode,
  input  wire logic [1:0]  outputCoding,
  output logic      [11:0] capWord,
  output logic      [11:0] capBin,
  output logic             capValid
);
  logic [11:0] pinLevel;
  logic [1:0]  riseDly = 2'h0;
  logic [1:0]  fallDly = 2'h0;
  logic        fwdPrev = 1'b0;
  // released pins read back inverted
  assign pinLevel = sampleData ^ ~sampleDataOe;
  always @(posedge mclk) begin
    fwdPrev <= forwardedSampleClock;
    riseDly <= {riseDly[0], forwardedSampleClock & ~fwdPrev};
    fallDly <= {fallDly[0], ~forwardedSampleClock & fwdPrev};
    capValid <= riseDly[1] && !ddrMode || fallDly[1] && ddrMode;
    if (riseDly[1] && !ddrMode) capWord <= pinLevel;
    for (int k = 0; k < 12; k += 2) begin
      if (riseDly[1] && ddrMode) capWord[k] <= pinLevel[k];
      if (fallDly[1] && ddrMode) capWord[k + 1] <= pinLevel[k];
    end
  end
  always_comb begin
    capBin = capWord ^ {outputCoding == 2'h1, 11'h0};
    if (outputCoding == 2'h2) begin
      for (int k = 10; k >= 0; k--) capBin[k] = capBin[k + 1] ^ capWord[k];
    end
  end
endmodule
`default_nettype wire

// file: tb_adc_output_format_power_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_adc_output_format_power_ctrl;
  logic        mclk = 0, rst = 1, clkEn = 1, sampleClk = 0, sampleValid = 0;
  logic        sampleOverRange = 0, calibrationResetN = 0, calibrationDone = 0, ddrMode = 0;
  logic        styleOverride = 0, codingOverride = 0, powerOverride = 0, converterIndexed = 0;
  logic [1:0]  outputStyleStrap = 0, powerStateStrap = 1, outputCodingStrap = 0;
  logic [1:0]  styleProgrammed = 0, codingProgrammed = 0, powerProgrammed = 0;
  logic [11:0] sampleRaw = 0, sampleData, sampleDataOe, capWord, capBin;
  logic        forwardedSampleClock, forwardedSampleClockOe, overRange, overRangeOe;
  logic        sampleReady, powerReady, capValid;
  logic [1:0]  outputStyle, outputCoding;
  logic [3:0]  powerState;
  int          num_errors = 0, checked = 0, cycles = 0;
  afpc_output_ctrl uut (.*);
  afpc_receiver_model rx (.*);
  initial forever #4 mclk = ~mclk;
  initial begin
    #3;
    forever begin
      #62 sampleClk = 1;
      #63 sampleClk = 0;
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [11:0] codeOf(input logic [11:0] s, input int c);
    if (c == 1) return s ^ 12'h800;
    if (c == 2) return s ^ (s >> 1);
    return s;
  endfunction
  task automatic waitCap();
    for (int i = 0; i < 100 && capValid !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
  endtask
  task automatic sendCheck(input logic [11:0] raw, input logic orf, input int c);
    logic [11:0] s;
    s = (raw == 12'hfff || orf) ? 12'hfff : raw;
    waitCap();
    sampleRaw = raw;
    sampleOverRange = orf;
    sampleValid = 1;
    while (sampleReady !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    sampleValid = 0;
    waitCap();
    check("coded word", capWord, codeOf(s, c));
    check("decoded word", capBin, s);
    check("over-range", overRange, s == 12'hfff);
  endtask
  initial begin
    int i, acc;
    void'($urandom(34));
    repeat (3) @(negedge mclk);
    rst = 0;
    repeat (5) @(negedge mclk);
    check("strap sleep", powerState, afpc_pkg::AFPC_PWR_SLEEP);
    rst = 1;
    powerStateStrap = 2'h0;
    @(negedge mclk);
    check("reset over-range", overRange, 1'b1);
    repeat (2) @(negedge mclk);
    rst = 0;
    repeat (40) @(negedge mclk);
    check("strap run", powerState, afpc_pkg::AFPC_PWR_RUN);
    check("calibration clock", forwardedSampleClock, 1'b0);
    calibrationResetN = 1;
    repeat (10) @(negedge mclk);
    calibrationDone = 1;
    for (i = 0; i < 3; i++) begin
      outputStyleStrap = 2'(i);
      styleProgrammed = 2'(2 - i);
      styleOverride = 0;
      repeat (5) @(negedge mclk);
      check("style strap", outputStyle, 16'(i));
      styleOverride = 1;
      @(negedge mclk) check("style programmed", outputStyle, 16'(2 - i));
    end
    for (i = 0; i < 12; i++) begin
      ddrMode = i >= 6;
      codingOverride = i % 6 > 2;
      outputCodingStrap = 2'(codingOverride ? (i + 1) % 3 : i % 3);
      codingProgrammed = 2'(i % 3);
      sendCheck(12'h000, 0, i % 3);
      sendCheck(12'hfff, 0, i % 3);
      sendCheck(12'($urandom), 1'($urandom), i % 3);
      sendCheck(12'h7ff, 1, i % 3);
    end
    ddrMode = 0;
    powerProgrammed = 2'h2;
    powerOverride = 1;
    repeat (5) @(negedge mclk);
    check("unindexed power", powerState, afpc_pkg::AFPC_PWR_RUN);
    converterIndexed = 1;
    repeat (5) @(negedge mclk);
    check("nap state", powerState, afpc_pkg::AFPC_PWR_NAP);
    check("nap enables", {sampleDataOe, forwardedSampleClockOe, overRangeOe}, 16'h0);
    acc = 0;
    sampleValid = 1;
    for (i = 0; i < 5; i++) begin
      if (sampleReady === 1'b1) acc++;
      @(negedge mclk);
    end
    sampleValid = 0;
    check("buffered words", 16'(acc), 16'h2);
    powerProgrammed = 2'h0;
    for (i = 0; i < 400 && powerReady !== 1'b1; i++) @(negedge mclk);
    check("nap wake time", i >= 115 && i <= 135, 1'b1);
    for (i = 0; i < 200 && sampleReady !== 1'b1; i++) @(negedge mclk);
    check("buffer drained", sampleReady, 1'b1);
    powerProgrammed = 2'h1;
    repeat (5) @(negedge mclk);
    check("sleep state", powerState, afpc_pkg::AFPC_PWR_SLEEP);
    powerProgrammed = 2'h0;
    repeat (200) @(negedge mclk);
    check("sleep wake pending", powerState, afpc_pkg::AFPC_PWR_WAKE);
    check("wake enables", {sampleDataOe, forwardedSampleClockOe, overRangeOe}, 16'h0);
    rst = 1;
    repeat (2) @(negedge mclk);
    rst = 0;
    repeat (2) @(negedge mclk);
    check("reset run", powerState, afpc_pkg::AFPC_PWR_RUN);
    conclude();
  end
endmodule
`default_nettype wire
